// File: src/cfs_top.sv
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - carrier code is whole kHz, with code 0 giving 0.7 kHz and code 15 giving 14.5 kHz.
// - spreading is off at select 0, and at select 1 (reset) runs only while the code is 0 to 5.
// - with auto select 1, code 3 or more and current held at 85 percent or more while running, carrier drops to 2 kHz.
// - with auto select 0 (reset) the carrier stays at the programmed code under any load.
// - carrier code and spread select take writes while running even with write protect at 0.
// - carrier, spread, auto and gain settings are writable only while extended display select is 0.
// - at 1 kHz or below the fast current limit can trip first, and stall select can turn it off.
// - smoothing gain takes 0 to 200 percent, resets to 0, and 100 percent is the tuning start.
// - a nonzero gain trims output frequency against current swings from mechanical resonance.
module cfs_top (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic motor_running,
    input wire logic [7:0] out_current_pct,
    output logic [17:0] carrier_level,
    output logic carrier_valley,
    output logic [3:0] carrier_code_eff,
    output logic carrier_reduced,
    output logic fast_limit_en,
    output logic signed [15:0] freq_trim
);
    import cfs_pkg::*;

    cfs_cfg_s cfg_q, cfg_d;
    logic [3:0] ext_q, ext_d;
    logic [1:0] prot_q, prot_d;
    logic fastoff_q, fastoff_d;
    logic [31:0] rdata_q, rdata_d;
    logic [2:0] sync_q;
    logic run_q, run_d;
    logic [15:0] hot_cnt_q, hot_cnt_d;
    logic red_q, red_d;
    logic [11:0] avg_q, avg_d;
    logic signed [15:0] trim_q, trim_d;
    logic hot, group_ok, run_ok, spread_on;
    logic signed [12:0] avg_step;
    logic signed [23:0] dev_x, gain_x, prod, neg_sh;
    logic [3:0] eff_code;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_comb begin
        cfg_d = cfg_q;
        ext_d = ext_q;
        prot_d = prot_q;
        fastoff_d = fastoff_q;
        group_ok = (ext_q == 4'h0) && (prot_q != PROT_ALL_LOCK);
        run_ok = !run_q || (prot_q == PROT_FREE);
        if (reg_wr) begin
            case (reg_addr)
                OFS_CARRIER: begin
                    if (group_ok && reg_wdata[31:0] <= 32'(CARRIER_MAX)) begin
                        cfg_d.carrier = reg_wdata[3:0];
                    end
                end
                OFS_SPREAD: begin
                    if (group_ok && reg_wdata[31:0] <= 32'h0000_0001) begin
                        cfg_d.spread = reg_wdata[0];
                    end
                end
                OFS_AUTO: begin
                    if (group_ok && run_ok && reg_wdata[31:0] <= 32'h0000_0001) begin
                        cfg_d.auto_red = reg_wdata[0];
                    end
                end
                OFS_GAIN: begin
                    if (group_ok && run_ok && reg_wdata[31:0] <= 32'(GAIN_MAX)) begin
                        cfg_d.gain = reg_wdata[7:0];
                    end
                end
                OFS_CTRL: begin
                    ext_d = reg_wdata[3:0];
                    prot_d = reg_wdata[CTRL_PROT_LSB +: 2];
                    fastoff_d = reg_wdata[CTRL_FASTOFF_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= '{carrier: CARRIER_RST, spread: SPREAD_RST, auto_red: AUTO_RST, gain: GAIN_RST};
            ext_q <= 4'h0;
            prot_q <= PROT_RUN_LOCK;
            fastoff_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            ext_q <= ext_d;
            prot_q <= prot_d;
            fastoff_q <= fastoff_d;
        end
    end

    // ----------------------------------------------------------------
    // read back, one cycle after the strobe
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CARRIER: rdata_d = {28'h000_0000, cfg_q.carrier};
                OFS_SPREAD: rdata_d = {31'h0000_0000, cfg_q.spread};
                OFS_AUTO: rdata_d = {31'h0000_0000, cfg_q.auto_red};
                OFS_GAIN: rdata_d = {24'h00_0000, cfg_q.gain};
                OFS_CTRL: begin
                    rdata_d[3:0] = ext_q;
                    rdata_d[CTRL_PROT_LSB +: 2] = prot_q;
                    rdata_d[CTRL_FASTOFF_BIT] = fastoff_q;
                end
                OFS_STATUS: begin
                    rdata_d[3:0] = eff_code;
                    rdata_d[ST_REDUCED_BIT] = red_q;
                    rdata_d[ST_SPREAD_BIT] = spread_on;
                    rdata_d[ST_RUN_BIT] = run_q;
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // run pin sync, load watch and carrier reduction
    // ----------------------------------------------------------------
    always_comb begin
        run_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : run_q;
        hot = out_current_pct >= HOT_PCT;
        hot_cnt_d = 16'h0000;
        if (run_q && hot) begin
            hot_cnt_d = (hot_cnt_q == 16'(HOT_CYCLES)) ? hot_cnt_q : hot_cnt_q + 16'h0001;
        end
        red_d = red_q;
        // sustained heavy load drops to 2 kHz
        if (cfg_q.auto_red && cfg_q.carrier >= CARRIER_AUTO_MIN && hot_cnt_q == 16'(HOT_CYCLES)) begin
            red_d = 1'b1;
        end
        // fixed carrier when auto is off; restore below threshold
        if (!cfg_q.auto_red || cfg_q.carrier < CARRIER_AUTO_MIN || !hot) begin
            red_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sync_q <= 3'h0;
            run_q <= 1'b0;
            hot_cnt_q <= 16'h0000;
            red_q <= 1'b0;
        end else begin
            sync_q <= {sync_q[1:0], motor_running};
            run_q <= run_d;
            hot_cnt_q <= hot_cnt_d;
            red_q <= red_d;
        end
    end

    assign eff_code = red_q ? CARRIER_REDUCED : cfg_q.carrier;
    // spreading only for codes 0 to 5
    assign spread_on = cfg_q.spread && cfg_q.carrier <= SPREAD_MAX_CODE;

    // ----------------------------------------------------------------
    // speed smoothing trim
    // ----------------------------------------------------------------
    always_comb begin
        avg_step = (13'sh0000 + $signed({1'b0, out_current_pct, 4'h0}) - $signed({1'b0, avg_q})) >>> 4;
        avg_d = avg_q + 12'(avg_step);
        dev_x = 24'(signed'({1'b0, out_current_pct})) - 24'(signed'({1'b0, avg_q[11:4]}));
        gain_x = 24'(signed'({1'b0, cfg_q.gain}));
        prod = dev_x * gain_x * TRIM_MUL;
        neg_sh = (24'sh00_0000 - prod) >>> TRIM_SHIFT;
        // oppose current swings, gain 100 percent is unity
        trim_d = (cfg_q.gain == GAIN_RST) ? 16'sh0000 : neg_sh[15:0];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            avg_q <= 12'h000;
            trim_q <= 16'sh0000;
        end else begin
            avg_q <= avg_d;
            trim_q <= trim_d;
        end
    end

    // ----------------------------------------------------------------
    // carrier generator
    // ----------------------------------------------------------------
    // code to period mapping
    cfs_carrier_gen u_gen (
        .core_clk(core_clk),
        .rstn(rstn),
        .half_period(cfs_half_period(eff_code)),
        .spread_en(spread_on),
        .carrier_level(carrier_level),
        .carrier_valley(carrier_valley)
    );

    assign reg_rdata = rdata_q;
    assign carrier_code_eff = eff_code;
    assign carrier_reduced = red_q;
    // stall select can disable the fast current limit
    assign fast_limit_en = !fastoff_q;
    assign freq_trim = trim_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_code_ends: assert property (cfs_half_period(4'h0) == 18'h2_2E09 && cfs_half_period(4'hF) == 18'h0_1AF0)
        else $error("carrier end codes map wrong");
    // lim is loaded at the valley edge, so it is checked one edge later against the code that stood before it
    a_spread_gate: assert property (carrier_valley |-> u_gen.lim_q >= $past(cfs_half_period(eff_code))
        && ($past(spread_on) || u_gen.lim_q == $past(cfs_half_period(eff_code))))
        else $error("spread active outside its range");
    a_auto_reduce: assert property (cfg_q.auto_red && cfg_q.carrier >= 4'h3 && hot && hot_cnt_q == 16'(HOT_CYCLES)
        |=> carrier_code_eff == 4'h2)
        else $error("carrier not reduced under load");
    a_fixed_carrier: assert property (!cfg_q.auto_red |-> carrier_code_eff == cfg_q.carrier && !carrier_reduced)
        else $error("carrier moved with auto off");
    a_run_write: assert property (reg_wr && reg_addr == OFS_CARRIER && ext_q == 4'h0 && prot_q == 2'h0 && run_q
        && reg_wdata <= 32'h0000_000F |=> cfg_q.carrier == $past(reg_wdata[3:0]))
        else $error("carrier write lost while running");
    a_ext_gate: assert property (reg_wr && ext_q != 4'h0 |=> $stable(cfg_q))
        else $error("setting changed with extended display set");
    a_fast_limit: assert property (reg_wr && reg_addr == OFS_CTRL |=> fast_limit_en == !$past(reg_wdata[8]))
        else $error("fast limit select not applied");
    a_gain_range: assert property (cfg_q.gain <= 8'hC8)
        else $error("smoothing gain above 200");
    a_trim_zero: assert property (cfg_q.gain == 8'h00 ##1 cfg_q.gain == 8'h00 |-> freq_trim == 16'sh0000)
        else $error("trim nonzero with zero gain");
    a_trim_sign: assert property (cfg_q.gain != 8'h00 && out_current_pct > avg_q[11:4]
        |=> freq_trim < 16'sh0000)
        else $error("trim does not oppose rising current");
    a_restore: assert property (carrier_reduced && out_current_pct < 8'h55 |=> !carrier_reduced ##0
        carrier_code_eff == cfg_q.carrier)
        else $error("carrier not restored");

    c_reduced: cover property (!carrier_reduced ##1 carrier_reduced);
    c_spread: cover property (spread_on && carrier_valley);
    c_refused: cover property (reg_wr && reg_addr == OFS_GAIN && run_q && prot_q == 2'h0);
endmodule

// File: pkg/cfs_pkg.sv
package cfs_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_FREQ_HZ = 200000000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int HOT_TIME_US = 10;
    localparam int HOT_CYCLES = (HOT_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CARRIER = 8'h00;
    localparam logic [7:0] OFS_SPREAD = 8'h04;
    localparam logic [7:0] OFS_AUTO = 8'h08;
    localparam logic [7:0] OFS_GAIN = 8'h0C;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ----------------------------------------------------------------
    // field positions, limits and reset values
    // ----------------------------------------------------------------
    localparam int CTRL_PROT_LSB = 4;
    localparam int CTRL_FASTOFF_BIT = 8;
    localparam int ST_REDUCED_BIT = 4;
    localparam int ST_SPREAD_BIT = 5;
    localparam int ST_RUN_BIT = 6;
    localparam logic [3:0] CARRIER_RST = 4'h1;
    localparam logic [3:0] CARRIER_MAX = 4'hF;
    localparam logic [3:0] CARRIER_REDUCED = 4'h2;
    localparam logic [3:0] CARRIER_AUTO_MIN = 4'h3;
    localparam logic [3:0] SPREAD_MAX_CODE = 4'h5;
    localparam logic SPREAD_RST = 1'b1;
    localparam logic AUTO_RST = 1'b0;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [7:0] GAIN_MAX = 8'hC8;
    localparam logic [7:0] HOT_PCT = 8'h55;
    localparam logic [1:0] PROT_RUN_LOCK = 2'h0;
    localparam logic [1:0] PROT_ALL_LOCK = 2'h1;
    localparam logic [1:0] PROT_FREE = 2'h2;
    localparam logic [7:0] LFSR_SEED = 8'hA5;
    localparam logic signed [23:0] TRIM_MUL = 24'sh00_0029;
    localparam int TRIM_SHIFT = 12;

    // ----------------------------------------------------------------
    // carried settings
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] carrier;
        logic spread;
        logic auto_red;
        logic [7:0] gain;
    } cfs_cfg_s;

    // carrier half period in core clocks; code 0 is 0.7 kHz, 15 is 14.5 kHz
    function automatic logic [17:0] cfs_half_period(input logic [3:0] code);
        int tenths;
        tenths = (code == 4'h0) ? 7 : (code == 4'hF) ? 145 : int'(code) * 10;
        return 18'(CLK_FREQ_HZ / (tenths * 200));
    endfunction

endpackage

// File: src/cfs_carrier_gen.sv
`timescale 1ns/1ps
module cfs_carrier_gen (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [17:0] half_period,
    input wire logic spread_en,
    output logic [17:0] carrier_level,
    output logic carrier_valley
);
    import cfs_pkg::*;

    logic [17:0] cnt_q, cnt_d, lim_q, lim_d;
    logic up_q, up_d, valley_q, valley_d;
    logic [7:0] lfsr_q, lfsr_d;
    logic [20:0] prod;

    // ----------------------------------------------------------------
    // triangle counter, limit reloaded at each valley
    // ----------------------------------------------------------------
    always_comb begin
        prod = 21'(half_period) * 21'(lfsr_q[2:0]);
        cnt_d = cnt_q;
        up_d = up_q;
        lim_d = lim_q;
        lfsr_d = lfsr_q;
        valley_d = 1'b0;
        if (up_q) begin
            if (cnt_q >= lim_q) begin
                up_d = 1'b0;
                cnt_d = cnt_q - 18'h0_0001;
            end else begin
                cnt_d = cnt_q + 18'h0_0001;
            end
        end else if (cnt_q <= 18'h0_0001) begin
            cnt_d = 18'h0_0000;
            up_d = 1'b1;
            valley_d = 1'b1;
            // spread: random stretch of up to 7/64 of the period
            lim_d = half_period + (spread_en ? {3'b000, prod[20:6]} : 18'h0_0000);
            lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        end else begin
            cnt_d = cnt_q - 18'h0_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 18'h0_0000;
            up_q <= 1'b1;
            lim_q <= 18'h0_0001;
            lfsr_q <= LFSR_SEED;
            valley_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            up_q <= up_d;
            lim_q <= lim_d;
            lfsr_q <= lfsr_d;
            valley_q <= valley_d;
        end
    end

    assign carrier_level = cnt_q;
    assign carrier_valley = valley_q;
endmodule

// File: tb/cfs_load_model.sv
`timescale 1ns/1ps
module cfs_load_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic run_cmd,
    input wire logic [7:0] load_cmd,
    input wire logic wobble_en,
    output logic motor_running,
    output logic [7:0] out_current_pct
);
    logic [3:0] ph_q;

    // ----------------------------------------------------------------
    // power stage and motor load
    // ----------------------------------------------------------------
    // run pin and current follow the command one edge later; wobble swings current by 20 points
    // load level is the operator's choice, heavy load only when commanded
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ph_q <= 4'h0;
            motor_running <= 1'b0;
            out_current_pct <= 8'h00;
        end else begin
            ph_q <= ph_q + 4'h1;
            motor_running <= run_cmd;
            if (wobble_en && ph_q[3]) begin
                out_current_pct <= load_cmd + 8'h14;
            end else if (wobble_en) begin
                out_current_pct <= load_cmd - 8'h14;
            end else begin
                out_current_pct <= load_cmd;
            end
        end
    end
endmodule

// File: tb/cfs_top_test.sv
`timescale 1ns/1ps
module cfs_top_test;
    import cfs_pkg::*;

    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} cfs_row_s;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic run_cmd = 1'b0;
    logic [7:0] load_cmd = 8'h00;
    logic wobble_en = 1'b0;
    logic motor_running;
    logic [7:0] out_current_pct;
    logic [17:0] carrier_level;
    logic carrier_valley;
    logic [3:0] carrier_code_eff;
    logic carrier_reduced;
    logic fast_limit_en;
    logic signed [15:0] freq_trim;
    int fails = 0;
    int n_compared = 0;
    int n;
    logic [31:0] rd;
    logic seen;
    cfs_row_s rows[8];

    // ----------------------------------------------------------------
    // clock, design and load
    // ----------------------------------------------------------------
    always #2.5 core_clk = ~core_clk;

    cfs_top dut_u (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .motor_running(motor_running),
        .out_current_pct(out_current_pct), .carrier_level(carrier_level), .carrier_valley(carrier_valley),
        .carrier_code_eff(carrier_code_eff), .carrier_reduced(carrier_reduced),
        .fast_limit_en(fast_limit_en), .freq_trim(freq_trim));

    cfs_load_model load_u (.core_clk(core_clk), .rstn(rstn), .run_cmd(run_cmd), .load_cmd(load_cmd),
        .wobble_en(wobble_en), .motor_running(motor_running), .out_current_pct(out_current_pct));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp_v);
        n_compared++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rdr(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // bounded wait; n ends as the cycle count at which the flag was seen
    task automatic wait_flag(input bit valley, input int lim, output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1 cnt++;
        end while (((valley ? carrier_valley : carrier_reduced) !== 1'b1) && cnt < lim);
        if (cnt >= lim) chk("wait bound", 0, 1);
    endtask

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rows = '{'{OFS_CARRIER, 32'h0000_0010, 32'h0000_000F}, '{OFS_SPREAD, 32'h0000_0000, 32'h0000_0000},
            '{OFS_SPREAD, 32'h0000_0002, 32'h0000_0000}, '{OFS_GAIN, 32'h0000_00C8, 32'h0000_00C8},
            '{OFS_GAIN, 32'h0000_00C9, 32'h0000_00C8}, '{OFS_GAIN, 32'h0000_0000, 32'h0000_0000},
            '{OFS_AUTO, 32'h0000_0001, 32'h0000_0001}, '{8'h18, 32'h0000_0005, 32'h0000_0000}};
        repeat (6) @(posedge core_clk);
        chk("eff in reset", carrier_code_eff, 1);
        chk("fast en in reset", fast_limit_en, 1);
        chk("trim in reset", freq_trim, 0);
        rstn <= 1'b1;
        wr(OFS_CARRIER, 32'h0000_000F);
        rdr(OFS_CARRIER, rd); chk("carrier", rd, 15);
        rdr(OFS_SPREAD, rd); chk("spread rst", rd, 1);
        rdr(OFS_AUTO, rd); chk("auto rst", rd, 0);
        rdr(OFS_GAIN, rd); chk("gain rst", rd, 0);
        rdr(OFS_CTRL, rd); chk("ctrl rst", rd, 0);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdr(rows[i].a, rd); chk("row readback", rd, rows[i].r);
        end
        $display("test table done");
        wait_flag(1'b1, 30000, n);
        chk("level at valley", carrier_level, 0);
        wait_flag(1'b1, 30000, n);
        chk("period code 15", n, 2 * (CLK_FREQ_HZ / (145 * 200)));
        $display("test period done");
        @(posedge core_clk);
        run_cmd <= 1'b1;
        load_cmd <= 8'h32;
        repeat (10) @(posedge core_clk);
        rdr(OFS_STATUS, rd); chk("status run", rd, 32'h0000_004F);
        wr(OFS_CARRIER, 32'h0000_0005);
        wr(OFS_SPREAD, 32'h0000_0001);
        rdr(OFS_STATUS, rd); chk("status spread", rd, 32'h0000_0065);
        wr(OFS_GAIN, 32'h0000_0064);
        rdr(OFS_GAIN, rd); chk("gain locked run", rd, 0);
        wr(OFS_CTRL, 32'h0000_0001);
        wr(OFS_CARRIER, 32'h0000_0007);
        rdr(OFS_CARRIER, rd); chk("ext locks", rd, 5);
        wr(OFS_CTRL, 32'h0000_0020);
        $display("test write gates done");
        @(posedge core_clk);
        load_cmd <= 8'h5A;
        wait_flag(1'b0, 2200, n);
        chk("reduce delay", n >= 1995 && n <= 2010, 1);
        chk("reduced code", carrier_code_eff, 2);
        @(posedge core_clk);
        load_cmd <= 8'h32;
        repeat (3) @(posedge core_clk);
        #1 chk("restored", carrier_reduced, 0);
        chk("restored code", carrier_code_eff, 5);
        wr(OFS_AUTO, 32'h0000_0000);
        load_cmd <= 8'h5A;
        repeat (2100) @(posedge core_clk);
        #1 chk("fixed under load", {carrier_reduced, carrier_code_eff}, 5);
        load_cmd <= 8'h32;
        $display("test reduction done");
        wr(OFS_CTRL, 32'h0000_0120);
        repeat (2) @(posedge core_clk);
        #1 chk("fast off", fast_limit_en, 0);
        wr(OFS_CTRL, 32'h0000_0020);
        repeat (2) @(posedge core_clk);
        #1 chk("fast on", fast_limit_en, 1);
        wobble_en <= 1'b1;
        seen = 1'b0;
        repeat (64) begin
            @(posedge core_clk);
            #1 seen = seen | (freq_trim !== 16'h0000);
        end
        chk("trim gain 0", seen, 0);
        wr(OFS_GAIN, 32'h0000_0064);
        seen = 1'b0;
        repeat (64) begin
            @(posedge core_clk);
            #1 seen = seen | (freq_trim !== 16'h0000 && freq_trim !== 16'hxxxx);
        end
        chk("trim active", seen, 1);
        $display("test trim done");
        // mid-run reset: outputs and settings return to their reset values
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk("level in reset", carrier_level, 0);
        chk("reduced in reset", carrier_reduced, 0);
        chk("trim mid reset", freq_trim, 0);
        chk("fast en mid reset", fast_limit_en, 1);
        @(posedge core_clk);
        rstn <= 1'b1;
        rdr(OFS_CARRIER, rd);
        chk("carrier mid rst", rd, 1);
        rdr(OFS_GAIN, rd);
        chk("gain mid rst", rd, 0);
        rdr(OFS_AUTO, rd);
        chk("auto mid rst", rd, 0);
        rdr(OFS_SPREAD, rd);
        chk("spread mid rst", rd, 1);
        rdr(OFS_CTRL, rd);
        chk("ctrl mid rst", rd, 0);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule
